//--- include/dlr_pkg.sv
package dlr_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] ADDR_REV    = 4'h0;
  localparam logic [3:0] ADDR_ERR    = 4'h1;
  localparam logic [3:0] ADDR_CTLA   = 4'h2;
  localparam logic [3:0] ADDR_CTLB   = 4'h3;
  localparam logic [3:0] ADDR_KEY    = 4'h7;
  localparam logic [3:0] ADDR_RESREQ = 4'h8;
  localparam logic [3:0] ADDR_CLKSEL = 4'h9;
  localparam logic [3:0] ADDR_SYSCTL = 4'hA;
  localparam logic [3:0] ADDR_SYSST  = 4'hB;
  localparam logic [3:0] ADDR_CRC    = 4'hC;

  // ****************************************
  // Field positions and masks
  // ****************************************
  localparam int CTA_GAPEN     = 7;
  localparam int CTA_PAR       = 5;
  localparam int CTA_TOF       = 4;
  localparam int CTA_RSO       = 3;
  localparam int CTB_NACK      = 4;
  localparam int CTB_CCD       = 3;
  localparam int CTB_DIS       = 2;
  localparam int KEY_UROW      = 5;
  localparam int KEY_NVM       = 4;
  localparam int KEY_ERASE     = 3;
  localparam int SYSCTL_UDONE  = 1;
  localparam int SYSCTL_CLKASK = 0;
  localparam int SYSST_PROG    = 3;
  localparam logic [7:0] CTLA_MASK = 8'hBF;
  localparam logic [7:0] CTLB_MASK = 8'h18;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] CTLA_RST   = 8'h00;
  localparam logic [7:0] CTLB_RST   = 8'h00;
  localparam logic [7:0] RESREQ_RST = 8'h00;
  localparam logic [1:0] CLKSEL_RST = 2'h3;
  localparam logic [1:0] CLKSEL_RSV = 2'h0;
  localparam logic       CLKASK_RST = 1'b1;
  localparam logic [7:0] RST_SIG    = 8'h59;
  localparam logic [7:0] RST_RUN    = 8'h00;
  localparam logic [2:0] ERR_NONE   = 3'h0;
  localparam logic [2:0] ERR_PARITY = 3'h1;
  localparam logic [2:0] ERR_FRAME  = 3'h2;
  localparam logic [2:0] ERR_TOUT   = 3'h3;
  localparam logic [2:0] ERR_CLKREC = 3'h4;
  localparam logic [2:0] ERR_RSV    = 3'h5;
  localparam logic [2:0] ERR_BUS    = 3'h6;
  localparam logic [2:0] ERR_CONT   = 3'h7;
  localparam logic [2:0] GUARD_RSV  = 3'h7;
  localparam logic [7:0] GUARD_MAX  = 8'h80;
  localparam logic [1:0] IB_GAP_BITS = 2'h2;
  localparam int TIMEOUT_CYCLES_DEF = 65536;

  typedef enum logic [1:0] {
    LNK_ON  = 2'b01,
    LNK_OFF = 2'b10
  } dlr_lnk_t;

endpackage

//--- include/dlr_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
// Turnaround guard and access wait timer hookup
interface dlr_tmr_if;
  logic       guard_start;
  logic [2:0] guard_sel;
  logic       guard_busy;
  logic       wait_start;
  logic       wait_done;
  logic       timeout_off;
  logic       timeout_hit;
  modport ctl (
    output guard_start,
    output guard_sel,
    output wait_start,
    output wait_done,
    output timeout_off,
    input  guard_busy,
    input  timeout_hit
  );
  modport tmr (
    input  guard_start,
    input  guard_sel,
    input  wait_start,
    input  wait_done,
    input  timeout_off,
    output guard_busy,
    output timeout_hit
  );
endinterface
`default_nettype wire

//--- src/dlr_link_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dlr_link_timer #(
  parameter int TIMEOUT_CYCLES = dlr_pkg::TIMEOUT_CYCLES_DEF
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  dlr_tmr_if.tmr    t
);
  localparam int CW = (TIMEOUT_CYCLES > 2) ? $clog2(TIMEOUT_CYCLES) : 1;
  localparam logic [CW-1:0] TO_LAST = CW'(TIMEOUT_CYCLES - 1);

  // Counter width assumes a sane wait limit
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 1048576)
  begin : g_chk
    $error("dlr_link_timer: TIMEOUT_CYCLES out of range");
  end

  typedef struct packed {
    logic [7:0]    guard_cnt;
    logic          to_run;
    logic [CW-1:0] to_cnt;
    logic          hit;
  } dlr_tmr_st_t;

  dlr_tmr_st_t s_q;
  dlr_tmr_st_t s_d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.hit = 1'b0;
    // Guard length halves with each code step
    if (t.guard_start && t.guard_sel != dlr_pkg::GUARD_RSV)
      s_d.guard_cnt = dlr_pkg::GUARD_MAX >> t.guard_sel;
    else if (s_q.guard_cnt != 8'h00)
      s_d.guard_cnt = s_q.guard_cnt - 8'h01;
    // Response wait: a restart wins over a stale run
    if (t.wait_start)
    begin
      s_d.to_run = 1'b1;
      s_d.to_cnt = '0;
    end
    else if (t.wait_done)
      s_d.to_run = 1'b0;
    else if (s_q.to_run)
    begin
      if (s_q.to_cnt == TO_LAST)
      begin
        s_d.to_run = 1'b0;
        s_d.hit    = ~t.timeout_off;
      end
      else
        s_d.to_cnt = s_q.to_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign t.guard_busy  = (s_q.guard_cnt != 8'h00);
  assign t.timeout_hit = s_q.hit;

  // ****************************************
  // Checks
  // ****************************************
  chk_guard_short: assert property (
    @(posedge clk_sys) disable iff (rst)
    (t.guard_start && t.guard_sel == 3'h6) |=> t.guard_busy ##1 t.guard_busy ##1 !t.guard_busy)
    else $error("guard time for code 6 is not two cycles");
  chk_timeout_mask: assert property (
    @(posedge clk_sys) disable iff (rst)
    t.timeout_hit |-> !$past(t.timeout_off))
    else $error("time-out flagged while detection is off");
endmodule
`default_nettype wire

//--- src/dlr_link_regs.sv
`timescale 1ns/1ps
`default_nettype none
module dlr_link_regs #(
  parameter logic [3:0] LINK_REV       = 4'h3,  // Arbitrary value
  parameter int         TIMEOUT_CYCLES = dlr_pkg::TIMEOUT_CYCLES_DEF
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       acc_valid,
  input  wire logic       acc_write,
  input  wire logic [3:0] acc_addr,
  input  wire logic [7:0] acc_wdata,
  output logic      [7:0] acc_rdata,
  output logic            acc_rvalid,
  input  wire logic       err_valid,
  input  wire logic [2:0] err_code,
  input  wire logic       link_wake,
  input  wire logic       key_erase_hit,
  input  wire logic       key_nvm_hit,
  input  wire logic       key_urow_hit,
  input  wire logic [7:0] sys_status,
  input  wire logic [2:0] crc_status,
  input  wire logic       bit_tick,
  input  wire logic       tx_byte_done,
  input  wire logic       tx_multibyte,
  output logic            tx_gap_hold,
  input  wire logic       rx_to_tx,
  output logic            tx_guard_busy,
  input  wire logic       acc_wait_start,
  input  wire logic       acc_resp,
  input  wire logic       ldst_busy,
  input  wire logic       sys_reset_seen,
  output logic            neg_ack_send,
  output logic            sys_reset_req,
  output logic            sys_clock_request,
  output logic            user_row_data_done,
  output logic            user_row_session_end,
  output logic            link_shutdown,
  output logic            phy_enable,
  output logic            parity_check_en,
  output logic            response_sig_en,
  output logic            contention_detect_en,
  output logic      [1:0] link_clock_sel
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    dlr_pkg::dlr_lnk_t lnk;
    logic [2:0]        err_sig;
    logic [7:0]        ctla;
    logic [7:0]        ctlb;
    logic [7:0]        keys;
    logic [7:0]        resreq;
    logic [1:0]        clksel;
    logic              clkask;
    logic [7:0]        rdata;
    logic              rvalid;
    logic              udone;
    logic              urow_end;
    logic              shutdown;
    logic [1:0]        ib_cnt;
    logic              neg_ack;
    logic              prog_seen;
  } dlr_regs_st_t;

  // Link-local reset image; the system reset request never reaches it
  localparam dlr_regs_st_t REG_RST = '{
    lnk:     dlr_pkg::LNK_ON,
    ctla:    dlr_pkg::CTLA_RST,
    ctlb:    dlr_pkg::CTLB_RST,
    resreq:  dlr_pkg::RESREQ_RST,
    clksel:  dlr_pkg::CLKSEL_RST,
    clkask:  dlr_pkg::CLKASK_RST,
    default: '0
  };

  dlr_regs_st_t s_q;
  dlr_regs_st_t s_d;
  logic [7:0]   rd_val;
  logic         lnk_on;
  logic         acc_rd;
  logic         acc_wr;
  logic         ev_ok;
  logic         prog_rise;
  logic         rst_rise;
  logic         dis_wr;

  dlr_tmr_if tmr ();

  dlr_link_timer #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
  ) u_tmr (
    .clk_sys (clk_sys),
    .rst     (rst),
    .t       (tmr)
  );

  // ****************************************
  // Decode
  // ****************************************
  // Only the link instruction port decodes here; no core bus exists
  assign lnk_on = (s_q.lnk == dlr_pkg::LNK_ON);
  assign acc_rd = acc_valid & ~acc_write & lnk_on;
  assign acc_wr = acc_valid & acc_write & lnk_on;
  assign dis_wr = acc_wr && acc_addr == dlr_pkg::ADDR_CTLB && acc_wdata[dlr_pkg::CTB_DIS];

  // Error filter: ignored checks raise nothing, code 5 never loads
  assign ev_ok = err_valid && lnk_on
               && err_code != dlr_pkg::ERR_NONE
               && err_code != dlr_pkg::ERR_RSV
               && !(err_code == dlr_pkg::ERR_PARITY && s_q.ctla[dlr_pkg::CTA_PAR])
               && !(err_code == dlr_pkg::ERR_CONT && s_q.ctlb[dlr_pkg::CTB_CCD]);

  assign prog_rise = sys_status[dlr_pkg::SYSST_PROG] & ~s_q.prog_seen;

  // Entry into system reset from the request register
  assign rst_rise = acc_wr && acc_addr == dlr_pkg::ADDR_RESREQ
                 && acc_wdata == dlr_pkg::RST_SIG && s_q.resreq != dlr_pkg::RST_SIG;

  // ****************************************
  // Timer hookup
  // ****************************************
  assign tmr.guard_start = rx_to_tx & lnk_on;
  assign tmr.guard_sel   = s_q.ctla[2:0];
  assign tmr.wait_start  = acc_wait_start & lnk_on;
  assign tmr.wait_done   = acc_resp | ~lnk_on;
  assign tmr.timeout_off = s_q.ctla[dlr_pkg::CTA_TOF];

  // ****************************************
  // Read mux
  // ****************************************
  always_comb
  begin
    rd_val = 8'h00;
    case (acc_addr)
      dlr_pkg::ADDR_REV:    rd_val = {LINK_REV, 4'h0};
      dlr_pkg::ADDR_ERR:    rd_val = {5'h00, s_q.err_sig};
      dlr_pkg::ADDR_CTLA:   rd_val = s_q.ctla;
      dlr_pkg::ADDR_CTLB:   rd_val = s_q.ctlb;
      dlr_pkg::ADDR_KEY:    rd_val = s_q.keys;
      dlr_pkg::ADDR_RESREQ: rd_val = s_q.resreq;
      dlr_pkg::ADDR_CLKSEL: rd_val = {6'h00, s_q.clksel};
      dlr_pkg::ADDR_SYSCTL: rd_val = {7'h00, s_q.clkask};
      dlr_pkg::ADDR_SYSST:  rd_val = sys_status;
      dlr_pkg::ADDR_CRC:    rd_val = {5'h00, crc_status};
      default:              rd_val = 8'h00;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.rvalid    = 1'b0;
    s_d.udone     = 1'b0;
    s_d.urow_end  = 1'b0;
    s_d.shutdown  = 1'b0;
    s_d.neg_ack   = 1'b0;
    s_d.prog_seen = sys_status[dlr_pkg::SYSST_PROG];
    unique case (s_q.lnk)
      dlr_pkg::LNK_ON:
      begin
        // Read answer, with clear-on-read of the error signature
        if (acc_rd)
        begin
          s_d.rdata  = rd_val;
          s_d.rvalid = 1'b1;
          if (acc_addr == dlr_pkg::ADDR_ERR)
            s_d.err_sig = dlr_pkg::ERR_NONE;
        end
        // Writes; reserved offsets fall through untouched
        if (acc_wr)
        begin
          case (acc_addr)
            dlr_pkg::ADDR_CTLA:
            begin
              s_d.ctla = acc_wdata & dlr_pkg::CTLA_MASK;
              // Reserved guard code keeps the old guard time
              if (acc_wdata[2:0] == dlr_pkg::GUARD_RSV)
                s_d.ctla[2:0] = s_q.ctla[2:0];
            end
            dlr_pkg::ADDR_CTLB:
              s_d.ctlb = acc_wdata & dlr_pkg::CTLB_MASK;
            dlr_pkg::ADDR_KEY:
              if (acc_wdata[dlr_pkg::KEY_UROW])
              begin
                s_d.keys[dlr_pkg::KEY_UROW] = 1'b0;
                s_d.urow_end = 1'b1;
              end
            dlr_pkg::ADDR_RESREQ:
            begin
              s_d.resreq = acc_wdata;
              if (acc_wdata == dlr_pkg::RST_SIG)
                s_d.keys[dlr_pkg::KEY_ERASE] = 1'b0;
            end
            dlr_pkg::ADDR_CLKSEL:
              if (acc_wdata[1:0] != dlr_pkg::CLKSEL_RSV)
                s_d.clksel = acc_wdata[1:0];
            dlr_pkg::ADDR_SYSCTL:
            begin
              s_d.clkask = acc_wdata[dlr_pkg::SYSCTL_CLKASK];
              // Done strobe only counts inside a user-row session
              if (acc_wdata[dlr_pkg::SYSCTL_UDONE] && s_q.keys[dlr_pkg::KEY_UROW])
                s_d.udone = 1'b1;
            end
            default:
            begin
            end
          endcase
        end
        // NVM key retires once programming may start
        if (prog_rise)
          s_d.keys[dlr_pkg::KEY_NVM] = 1'b0;
        // Key decodes after the clears, so a coincident set wins
        if (key_erase_hit)
          s_d.keys[dlr_pkg::KEY_ERASE] = 1'b1;
        if (key_nvm_hit)
          s_d.keys[dlr_pkg::KEY_NVM] = 1'b1;
        if (key_urow_hit)
          s_d.keys[dlr_pkg::KEY_UROW] = 1'b1;
        // Errors load after the read clear; an event code overwrites a coincident time-out
        if (tmr.timeout_hit)
          s_d.err_sig = dlr_pkg::ERR_TOUT;
        if (ev_ok)
          s_d.err_sig = err_code;
        // NACK on system reset during a load or store
        if ((rst_rise || sys_reset_seen) && ldst_busy && !s_q.ctlb[dlr_pkg::CTB_NACK])
          s_d.neg_ack = 1'b1;
        // Inter-byte gap counted in idle bit times
        if (s_q.ib_cnt != 2'h0 && bit_tick)
          s_d.ib_cnt = s_q.ib_cnt - 2'h1;
        if (tx_byte_done && tx_multibyte && s_q.ctla[dlr_pkg::CTA_GAPEN])
          s_d.ib_cnt = dlr_pkg::IB_GAP_BITS;
        // Disable overrides everything: settings and keys go back to reset, except the clock request, which drops
        if (dis_wr)
        begin
          s_d          = REG_RST;
          s_d.lnk      = dlr_pkg::LNK_OFF;
          s_d.clkask   = 1'b0;
          s_d.shutdown = 1'b1;
        end
      end
      dlr_pkg::LNK_OFF:
        // Re-enable brings the clock request back up
        if (link_wake)
          s_d = REG_RST;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      s_q <= REG_RST;
    else
      s_q <= s_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign acc_rdata            = s_q.rdata;
  assign acc_rvalid           = s_q.rvalid;
  assign tx_gap_hold          = (s_q.ib_cnt != 2'h0);
  assign tx_guard_busy        = tmr.guard_busy;
  assign neg_ack_send         = s_q.neg_ack;
  // Reserved request codes leave the system running
  assign sys_reset_req        = (s_q.resreq == dlr_pkg::RST_SIG);
  assign sys_clock_request    = s_q.clkask;
  assign user_row_data_done   = s_q.udone;
  assign user_row_session_end = s_q.urow_end;
  assign link_shutdown        = s_q.shutdown;
  assign phy_enable           = lnk_on;
  assign parity_check_en      = ~s_q.ctla[dlr_pkg::CTA_PAR];
  assign response_sig_en      = ~s_q.ctla[dlr_pkg::CTA_RSO];
  assign contention_detect_en = lnk_on & ~s_q.ctlb[dlr_pkg::CTB_CCD];
  assign link_clock_sel       = s_q.clksel;

  // ****************************************
  // Checks
  // ****************************************
  chk_wake_sys_clock_request: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!lnk_on && link_wake) |=> (sys_clock_request && phy_enable))
    else $error("clock request not raised on link enable");
  chk_rev_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    (acc_rd && acc_addr == dlr_pkg::ADDR_REV) |=> (acc_rvalid && acc_rdata == {LINK_REV, 4'h0}))
    else $error("revision read returned wrong value");
  chk_err_rdclr: assert property (
    @(posedge clk_sys) disable iff (rst)
    (acc_rd && acc_addr == dlr_pkg::ADDR_ERR && !ev_ok && !tmr.timeout_hit && !dis_wr)
      |=> s_q.err_sig == dlr_pkg::ERR_NONE)
    else $error("error signature not cleared by read");
  chk_parity_drop: assert property (
    @(posedge clk_sys) disable iff (rst)
    (err_valid && err_code == dlr_pkg::ERR_PARITY && parity_check_en == 1'b0
      && !acc_valid && !tmr.timeout_hit) |=> $stable(s_q.err_sig))
    else $error("parity error loaded while parity ignored");
  chk_gap_len: assert property (
    @(posedge clk_sys) disable iff (rst)
    (lnk_on && tx_byte_done && tx_multibyte && s_q.ctla[dlr_pkg::CTA_GAPEN] && !dis_wr)
      |=> (tx_gap_hold && s_q.ib_cnt == dlr_pkg::IB_GAP_BITS))
    else $error("inter-byte gap not started");
  chk_rst_req: assert property (
    @(posedge clk_sys) disable iff (rst)
    (acc_wr && acc_addr == dlr_pkg::ADDR_RESREQ) |=>
      (sys_reset_req == ($past(acc_wdata) == dlr_pkg::RST_SIG)))
    else $error("system reset request does not follow written value");
  chk_erase_clr: assert property (
    @(posedge clk_sys) disable iff (rst)
    (acc_wr && acc_addr == dlr_pkg::ADDR_RESREQ && acc_wdata == dlr_pkg::RST_SIG
      && !key_erase_hit) |=> !s_q.keys[dlr_pkg::KEY_ERASE])
    else $error("erase key not cleared by reset request");
  chk_disable_off: assert property (
    @(posedge clk_sys) disable iff (rst)
    dis_wr |=> (!sys_clock_request && !phy_enable && link_shutdown && !sys_reset_req
      && s_q.keys == 8'h00) ##1 !link_shutdown)
    else $error("link disable did not shut down and clear");
  chk_nack_gate: assert property (
    @(posedge clk_sys) disable iff (rst)
    neg_ack_send |-> ($past(ldst_busy) && !$past(s_q.ctlb[dlr_pkg::CTB_NACK])))
    else $error("negative acknowledge sent while suppressed");
endmodule
`default_nettype wire

//--- bench/dlr_dbg_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Debugger side of the register port
// ****************************************
module dlr_dbg_model (
  input  wire logic       clk_sys,
  output logic            acc_valid,
  output logic            acc_write,
  output logic      [3:0] acc_addr,
  output logic      [7:0] acc_wdata,
  input  wire logic [7:0] acc_rdata,
  input  wire logic       acc_rvalid
);
  // Idle port at time zero
  initial
  begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr  = 4'h0;
    acc_wdata = 8'h00;
  end

  // One request per edge; released lines flip so stale values never match
  task automatic req(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_addr  <= a;
    acc_wdata <= d;
    @(posedge clk_sys);
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
    acc_wdata <= ~d;
  endtask

  // Read answer lands on the same edge that takes the request
  task automatic rd(input logic [3:0] a, output logic [7:0] v, output logic ok);
    req(1'b0, a, 8'h00);
    #1;
    ok = acc_rvalid;
    v  = acc_rdata;
  endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Register bank bench
// ****************************************
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [12:0] ev = 13'h0000;
  logic [2:0]  err_code = 3'h0;
  logic [7:0]  sys_st, acc_wdata, acc_rdata;
  logic [2:0]  crc_st;
  logic        acc_valid, acc_write, acc_rvalid, ok;
  logic [3:0]  acc_addr;
  logic [7:0]  m [16];
  logic [1:0]  clk_sel;
  logic [11:0] o;
  logic [31:0] seed = 32'h69DE27AD, v;
  int          err_total = 0, checked = 0, cyc = 0, n;

  dlr_link_regs #(.LINK_REV(4'h3), .TIMEOUT_CYCLES(16)) i_dlr_link_regs (
    .clk_sys(clk_sys), .rst(rst), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
    .err_valid(ev[0]), .err_code(err_code), .link_wake(ev[1]), .key_erase_hit(ev[2]),
    .key_nvm_hit(ev[3]), .key_urow_hit(ev[4]), .sys_status(sys_st), .crc_status(crc_st),
    .bit_tick(ev[5]), .tx_byte_done(ev[6]), .tx_multibyte(ev[7]), .tx_gap_hold(o[0]),
    .rx_to_tx(ev[8]), .tx_guard_busy(o[1]), .acc_wait_start(ev[9]), .acc_resp(ev[10]),
    .ldst_busy(ev[11]), .sys_reset_seen(ev[12]), .neg_ack_send(o[2]), .sys_reset_req(o[3]),
    .sys_clock_request(o[4]), .user_row_data_done(o[5]), .user_row_session_end(o[6]),
    .link_shutdown(o[7]), .phy_enable(o[8]), .parity_check_en(o[9]), .response_sig_en(o[10]),
    .contention_detect_en(o[11]), .link_clock_sel(clk_sel));

  dlr_dbg_model i_dlr_dbg_model (.clk_sys(clk_sys), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));

  // Half-period toggle, 100 ns period
  always #50 clk_sys = ~clk_sys;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Model of the register image after any reset
  task automatic init_m();
    for (int i = 0; i < 16; i++)
      m[i] = 8'h00;
    m[0] = 8'h30;
    m[9] = 8'h03;
    m[10] = 8'h01;
    m[11] = sys_st;
    m[12] = {5'h00, crc_st};
  endtask

  task automatic pulse(input int i);
    @(posedge clk_sys);
    ev[i] <= 1'b1;
    @(posedge clk_sys);
    ev[i] <= 1'b0;
    #1;
  endtask

  task automatic r(input logic [3:0] a);
    logic [7:0] d;
    i_dlr_dbg_model.rd(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, m[a]);
    if (a == 4'h1)
      m[1] = 8'h00;
  endtask

  // Write and mirror the effect in the model
  task automatic w(input logic [3:0] a, input logic [7:0] d);
    i_dlr_dbg_model.req(1'b1, a, d);
    #1;
    case (a)
      4'h2: m[2] = (d[2:0] == 3'h7) ? {d[7:3] & 5'h17, m[2][2:0]} : d & 8'hBF;
      4'h3: m[3] = d & 8'h18;
      4'h7: if (d[5]) m[7][5] = 1'b0;
      4'h8: m[8] = d;
      4'h9: if (d[1:0] != 2'h0) m[9] = {6'h00, d[1:0]};
      default: ;
    endcase
    if (a == 4'h8 && d == 8'h59)
      m[7][3] = 1'b0;
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      close_out();
    end
  end

  initial
  begin
    v = xs();
    sys_st = v[7:0] & 8'hF7;
    crc_st = v[10:8];
    init_m();
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++)
      r(a[3:0]);
    chk({7'h00, o[4]}, 8'h01);
    foreach (m[i])
      if (i inside {1, 2, 4, 6, 7})
      begin
        err_code <= i[2:0];
        pulse(0);
        m[1] = i[7:0];
        r(1);
        r(1);
      end
    pulse(9);
    repeat (20) @(posedge clk_sys);
    m[1] = 8'h03;
    r(1);
    // Refused events: codes 0 and 5, ignored parity and contention, masked time-out
    w(2, 8'h30);
    w(3, 8'h08);
    pulse(9);
    foreach (m[i])
      if (i inside {0, 1, 5, 7})
      begin
        err_code <= i[2:0];
        pulse(0);
      end
    repeat (20) @(posedge clk_sys);
    r(1);
    for (int g = 0; g < 7; g++)
    begin
      w(2, g[7:0]);
      pulse(8);
      n = 0;
      repeat (140) @(negedge clk_sys) n += o[1];
      chk(n[7:0], 8'h80 >> g);
    end
    // Reserved guard code keeps the previous guard time
    w(2, 8'h07);
    r(2);
    repeat (4)
    begin
      v = xs();
      w(2, v[7:0]);
      r(2);
      chk({7'h00, o[9]}, {7'h00, ~m[2][5]});
      chk({7'h00, o[10]}, {7'h00, ~m[2][3]});
    end
    w(2, 8'h80);
    ev[7] <= 1'b1;
    pulse(6);
    chk({7'h00, o[0]}, 8'h01);
    pulse(5);
    chk({7'h00, o[0]}, 8'h01);
    pulse(5);
    chk({7'h00, o[0]}, 8'h00);
    w(3, 8'h08);
    chk({7'h00, o[11]}, 8'h00);
    w(3, 8'h00);
    chk({7'h00, o[11]}, 8'h01);
    ev[11] <= 1'b1;
    pulse(12);
    chk({7'h00, o[2]}, 8'h01);
    w(3, 8'h10);
    pulse(12);
    chk({7'h00, o[2]}, 8'h00);
    pulse(2);
    pulse(3);
    pulse(4);
    m[7] = 8'h38;
    r(7);
    sys_st <= 8'h08;
    m[11] = 8'h08;
    m[7] = 8'h28;
    r(7);
    w(8, 8'h59);
    chk({7'h00, o[3]}, 8'h01);
    r(7);
    w(10, 8'h03);
    chk({7'h00, o[5]}, 8'h01);
    w(7, 8'h20);
    chk({7'h00, o[6]}, 8'h01);
    r(7);
    w(8, 8'h00);
    chk({7'h00, o[3]}, 8'h00);
    w(9, 8'h01);
    w(9, 8'h00);
    r(9);
    chk({6'h00, clk_sel}, 8'h01);
    w(5, 8'hFF);
    r(5);
    pulse(2);
    w(3, 8'h04);
    chk({7'h00, o[7]}, 8'h01);
    chk({7'h00, o[8]}, 8'h00);
    chk({7'h00, o[4]}, 8'h00);
    i_dlr_dbg_model.rd(4'h0, v[7:0], ok);
    chk({7'h00, ok}, 8'h00);
    pulse(1);
    init_m();
    r(3);
    r(7);
    r(9);
    r(10);
    close_out();
  end
endmodule
`default_nettype wire
